/* File: bench/csab_core_store_properties.sv */
// concurrent checks on the ports of the core store block
`timescale 1ns/1ps
module csab_core_store_properties
  import csab_pkg::*;
(
  input wire logic          i_clk,
  input wire logic          i_sys_rst,
  input wire csab_axi_req_s i_axi,
  input wire csab_axi_rsp_s o_axi,
  input wire logic          i_read_drive,
  input wire logic          i_write_drive,
  input wire logic          i_dummy_drive,
  input wire logic          i_capture,
  input wire logic          i_cap_to_op,
  input wire logic [15:0]   o_vdrv_rd,
  input wire logic [15:0]   o_hdrv_wr,
  input wire logic [31:0]   o_vdiv,
  input wire logic [31:0]   o_hdiv,
  input wire logic          o_dummy_en,
  input wire logic [47:0]   o_inhibit,
  input wire logic          o_op_load
);
  // ------------------------------------------------------------
  // helper: length of the current dummy-off window
  // ------------------------------------------------------------
  int low_cnt;  // low samples of the dummy enable so far

  always_ff @(posedge i_clk) begin
    if (i_sys_rst || o_dummy_en) low_cnt <= 0;
    else low_cnt <= low_cnt + 1;
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  a_drv_one_div: assert property (o_vdrv_rd != 0 |-> $onehot(o_vdrv_rd) && $onehot(o_vdiv))
    else $error("driver active without exactly one driver and one diverter");
  a_rd_drv_strobe: assert property (o_vdrv_rd != 0 |-> $past(i_read_drive) && o_hdrv_wr == 0)
    else $error("read driver without read drive");
  a_wr_drv_strobe: assert property (o_hdrv_wr != 0 |-> $past(i_write_drive))
    else $error("write driver without write drive");
  a_inhibit_gate: assert property (o_inhibit != 0 |-> $past(i_write_drive))
    else $error("inhibit outside write drive");
  a_dummy_start: assert property ($fell(o_dummy_en) |-> $past(i_dummy_drive, 2))
    else $error("dummy load dropped without dummy drive");
  a_dummy_width: assert property ($rose(o_dummy_en) |-> low_cnt == DUMMY_CYC)
    else $error("dummy load off window has wrong length");
  a_div_hold: assert property (o_vdiv != 0 && $past(o_vdiv) != 0 |-> $stable(o_hdiv))
    else $error("diverter selection changed within a reference");
  a_op_pulse: assert property (o_op_load |-> $past(i_capture && i_cap_to_op) ##1 !o_op_load)
    else $error("operand load pulse without qualified capture");
  a_bresp_hold: assert property (o_axi.bvalid && !i_axi.bready |=> o_axi.bvalid)
    else $error("write response dropped before taken");

  c_read_drv: cover property (o_vdrv_rd != 0);
  c_write_drv: cover property (o_hdrv_wr != 0 && o_inhibit != 0);
  c_dummy_end: cover property ($rose(o_dummy_en));
  c_op_load: cover property (o_op_load);
endmodule

/* File: bench/csab_seq_model.sv */
// behavioural storage sequence control feeding the drive strobes
`timescale 1ns/1ps
module csab_seq_model (
  input  wire logic       i_clk,
  input  wire logic       i_sys_rst,
  input  wire logic       i_go,     // load accepted, start a reference
  input  wire logic       i_wr,     // write reference
  input  wire logic [3:0] i_gap,    // extra idle cycles, slows the far side
  output logic            o_read_drive,
  output logic            o_write_drive,
  output logic            o_dummy_drive,
  output logic            o_read_strobe,
  output logic            o_write_strobe,
  output logic            o_capture
);
  int cnt;  // cycles since start, -1 when idle
  int ws;   // write drive start, moves with the gap

  assign ws = 312 + int'(i_gap);

  // sequence counter; stands still between references
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) cnt <= -1;
    else if (i_go) cnt <= 0;
    else if (cnt >= 0 && cnt < ws + 320) cnt <= cnt + 1;
    else cnt <= -1;
  end

  // read in the first half, write in the second
  assign o_read_drive   = cnt >= 2 && cnt < 302;
  assign o_write_drive  = cnt >= ws && cnt < ws + 320;
  assign o_dummy_drive  = cnt >= 2 && cnt < 12;
  // capture late in the read drive, after the noise decays
  assign o_capture      = cnt == 172;
  assign o_read_strobe  = o_read_drive && !i_wr;
  assign o_write_strobe = o_read_drive && i_wr;
endmodule

/* File: bench/testbench.sv */
// self-checking bench for the core store address and bit-plane block
`timescale 1ns/1ps
module testbench;
  import csab_pkg::*;
  logic          i_clk, i_sys_rst, ld_i, ld_p, ld_s, rwr, cto, ctc, go, rd, wd, dd, rs, ws, cap;
  logic          busy, dmy, opl, ctl;
  csab_axi_req_s axi;
  csab_axi_rsp_s rsp;
  logic [14:0]   ia, pa;
  logic [2:0]    ps;
  logic [3:0]    qs, gap;
  logic [47:0]   sen, opd, inh, wrd;
  logic [15:0]   vr, vw, hr, hw;
  logic [31:0]   vd, hd, rdat;
  logic [1:0]    rr;
  int            num_errors, total_checks, seed, ld_cnt;

  csab_core_store csab_core_store_i (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_axi(axi),
    .o_axi(rsp), .i_load_instr(ld_i), .i_instr_addr(ia), .i_load_prog(ld_p), .i_prog_addr(pa),
    .i_load_preset(ld_s), .i_preset_sel(ps), .i_ref_write(rwr), .i_read_drive(rd),
    .i_write_drive(wd), .i_dummy_drive(dd), .i_read_strobe(rs), .i_write_strobe(ws),
    .i_quad_sel(qs), .i_sense(sen), .i_operand(opd), .i_capture(cap), .i_cap_to_op(cto),
    .i_cap_to_ctl(ctc), .o_vdrv_rd(vr), .o_vdrv_wr(vw), .o_hdrv_rd(hr), .o_hdrv_wr(hw),
    .o_vdiv(vd), .o_hdiv(hd), .o_dummy_en(dmy), .o_inhibit(inh), .o_word(wrd),
    .o_op_load(opl), .o_ctl_load(ctl), .o_busy(busy));
  csab_seq_model csab_seq_model_i (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_go(go), .i_wr(rwr),
    .i_gap(gap), .o_read_drive(rd), .o_write_drive(wd), .o_dummy_drive(dd),
    .o_read_strobe(rs), .o_write_strobe(ws), .o_capture(cap));

  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  // load pulse tally, an operand load counts two
  always @(posedge i_clk) ld_cnt <= ld_cnt + (opl ? 2 : 0) + (ctl ? 1 : 0);

  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic chk(input string nm, input logic [47:0] e, input logic [47:0] g);
    total_checks++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic give_verdict;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // write: address and data offered together, each released when taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    axi <= '{awvalid: 1'b1, awaddr: a, wvalid: 1'b1, wdata: d, wstrb: 4'hf, bready: 1'b1,
             default: '0};
    do begin
      @(posedge i_clk);
      if (rsp.awready) axi.awvalid <= 1'b0;
      if (rsp.wready) axi.wvalid <= 1'b0;
      n++;
    end while (!rsp.bvalid && n < 100);
    chk("bvalid", 48'h1, 48'(rsp.bvalid));
    chk("bresp", 48'(er), 48'(rsp.bresp));
    axi.bready <= 1'b0;
    repeat (2) @(posedge i_clk);
  endtask

  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e,
                      input logic [1:0] er);
    int n;
    n = 0;
    @(posedge i_clk);
    axi.arvalid <= 1'b1;
    axi.araddr <= a;
    axi.rready <= 1'b1;
    do begin
      @(posedge i_clk);
      if (rsp.arready) axi.arvalid <= 1'b0;
      n++;
    end while (!rsp.rvalid && n < 100);
    chk("rvalid", 48'h1, 48'(rsp.rvalid));
    chk(nm, 48'(e), 48'(rsp.rdata));
    chk("rresp", 48'(er), 48'(rsp.rresp));
    axi.rready <= 1'b0;
    repeat (2) @(posedge i_clk);
  endtask

  function automatic logic [15:0] drv(input logic b, input logic [2:0] k);
    return 16'h0001 << {b, k};
  endfunction

  function automatic logic [31:0] dvr(input logic b, input logic [3:0] k);
    return 32'h0000_0001 << {b, k};
  endfunction

  // one reference; src 0 instr, 1 prog, 2 preset, 3 instr and prog together
  task automatic do_ref(input logic [14:0] a, input logic w, input int src);
    logic [47:0] s, o, wb;
    int n, b0;
    if (src == 2) a[14:3] = '0;
    b0 = ld_cnt;
    s = {16'($random(seed)), 32'($random(seed))};
    o = {16'($random(seed)), 32'($random(seed))};
    wb = w ? o : s;
    n = 0;
    sen <= s;
    opd <= o;
    rwr <= w;
    gap <= 4'($random(seed));
    qs <= 4'($random(seed)) | 4'h1;
    cto <= !w && s[0];
    ctc <= !w && !s[0];
    ia <= (src == 1) ? ~a : a;
    pa <= (src == 1) ? a : ~a;
    ps <= a[2:0];
    ld_i <= (src == 0 || src == 3);
    ld_p <= (src == 1 || src == 3);
    ld_s <= (src == 2);
    go <= 1'b1;
    @(posedge i_clk);
    {ld_i, ld_p, ld_s, go} <= 4'h0;
    while (!rd && n < 50) begin
      @(posedge i_clk);
      n++;
    end
    repeat (200) @(posedge i_clk);
    ld_s <= 1'b1;
    ps <= ~a[2:0];
    @(posedge i_clk);
    ld_s <= 1'b0;
    @(negedge i_clk);
    chk("vdrv_rd", 48'(drv(a[0], {a[1], a[8], a[7]})), 48'(vr));
    chk("hdrv_rd", 48'(drv(a[0], {a[2], a[14], a[13]})), 48'(hr));
    chk("vdrv_wr", 48'h0, 48'(vw));
    chk("vdiv", 48'(dvr(a[0], a[6:3])), 48'(vd));
    chk("hdiv", 48'(dvr(a[0], a[12:9])), 48'(hd));
    chk("dummy", 48'h0, 48'(dmy));
    if (!w) chk("word", s, wrd);
    chk("op ctl load", 48'(w ? 0 : (s[0] ? 2 : 1)), 48'(ld_cnt - b0));
    while (!wd && n < 600) begin
      @(negedge i_clk);
      n++;
    end
    repeat (5) @(negedge i_clk);
    chk("inhibit", ~wb, inh);
    chk("hdrv_wr", 48'(drv(a[0], {a[2], a[14], a[13]})), 48'(hw));
    chk("vdrv_wr on", 48'(drv(a[0], {a[1], a[8], a[7]})), 48'(vw));
    while (busy !== 1'b0 && n < 1500) begin
      @(negedge i_clk);
      n++;
    end
    chk("dummy idle", 48'h1, 48'(dmy));
    chk("vdiv idle", 48'h0, 48'(vd));
    rchk("bank", a[0] ? OFS_BANK1 : OFS_BANK0, 32'(a), RESP_OK);
    rchk("wb_lo", OFS_WB_LO, wb[31:0], RESP_OK);
    rchk("wb_hi", OFS_WB_HI, {16'h0000, wb[47:32]}, RESP_OK);
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    seed = 80199;
    i_sys_rst = 1'b1;
    axi = '0;
    {ld_i, ld_p, ld_s, rwr, cto, ctc, go} = 7'h00;
    {ia, pa, ps, qs, gap} = '0;
    {sen, opd} = '0;
    repeat (3) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    @(posedge i_clk);
    rchk("ctrl", OFS_CTRL, 32'h0000_0001, RESP_OK);
    rchk("unmapped", 8'h40, 32'h0000_0000, RESP_ERR);
    axi_wr(OFS_REFS, 32'($random(seed)), RESP_OK);
    axi_wr(8'h40, 32'h0000_0001, RESP_ERR);
    rchk("refs ro", OFS_REFS, 32'h0000_0000, RESP_OK);
    for (int i = 0; i < 8; i++) do_ref(15'(i), 1'($random(seed)), 2);
    do_ref(15'h7fff, 1'b1, 0);
    do_ref(15'h0000, 1'b0, 1);
    for (int i = 0; i < 8; i++) do_ref(15'($random(seed)), 1'($random(seed)), i % 4);
    rchk("refs", OFS_REFS, 32'h0000_0012, RESP_OK);
    axi_wr(OFS_CTRL, 32'h0000_0000, RESP_OK);
    ld_i <= 1'b1;
    repeat (3) @(posedge i_clk);
    ld_i <= 1'b0;
    repeat (2) @(negedge i_clk);
    chk("busy disabled", 48'h0, 48'(busy));
    give_verdict;
  end

  initial begin
    #400_000;
    num_errors++;
    give_verdict;
  end
endmodule

bind csab_core_store csab_core_store_properties csab_core_store_properties_i (.i_clk, .i_sys_rst,
  .i_axi, .o_axi, .i_read_drive, .i_write_drive, .i_dummy_drive, .i_capture, .i_cap_to_op,
  .o_vdrv_rd, .o_hdrv_wr, .o_vdiv, .o_hdiv, .o_dummy_en, .o_inhibit, .o_op_load);

/* File: src/csab_core_store.sv */
// address hold, driver/diverter translation and bit-plane data path
`timescale 1ns/1ps
// Operation
// - fourteen-stage bank register only holds address
// - three load commands fill bank register
// - preset loads address 00000 to 00007
// - copies are forced, no prior clear
// - vertical driver from stages 01, 07, 08
// - horizontal driver from stages 02, 13, 14
// - driver is strobe-low term AND pair term
// - one driver per axis, read and write
// - dummy load off 6.2 us per reference
// - dummy window need not match drivers
// - vertical diverter from stages 03 to 06
// - horizontal diverter from stages 09 to 12
// - diverter is low pair AND high pair
// - read strobe routes sense into bank rank
// - write strobe routes operand into bank rank
// - capture loads write-back, operand or control
// - read out first half, write second
// - inhibit each zero bit during write drive
// - read clears word, write-back always follows
// - sense sampled late in read drive
// - address bit zero picks bank, rest stored
module csab_core_store (
  input  wire logic                   i_clk,
  input  wire logic                   i_sys_rst,
  input  wire csab_pkg::csab_axi_req_s i_axi,
  output csab_pkg::csab_axi_rsp_s     o_axi,
  input  wire logic                   i_load_instr,
  input  wire logic [14:0]            i_instr_addr,
  input  wire logic                   i_load_prog,
  input  wire logic [14:0]            i_prog_addr,
  input  wire logic                   i_load_preset,
  input  wire logic [2:0]             i_preset_sel,
  input  wire logic                   i_ref_write,
  input  wire logic                   i_read_drive,
  input  wire logic                   i_write_drive,
  input  wire logic                   i_dummy_drive,
  input  wire logic                   i_read_strobe,
  input  wire logic                   i_write_strobe,
  input  wire logic [3:0]             i_quad_sel,
  input  wire logic [47:0]            i_sense,
  input  wire logic [47:0]            i_operand,
  input  wire logic                   i_capture,
  input  wire logic                   i_cap_to_op,
  input  wire logic                   i_cap_to_ctl,
  output logic [15:0]                 o_vdrv_rd,
  output logic [15:0]                 o_vdrv_wr,
  output logic [15:0]                 o_hdrv_rd,
  output logic [15:0]                 o_hdrv_wr,
  output logic [31:0]                 o_vdiv,
  output logic [31:0]                 o_hdiv,
  output logic                        o_dummy_en,
  output logic [47:0]                 o_inhibit,
  output logic [47:0]                 o_word,
  output logic                        o_op_load,
  output logic                        o_ctl_load,
  output logic                        o_busy
);
  import csab_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [14:1]       s_reg [NBANK];   // bank address registers
  logic [WORD_W-1:0] inv_reg [NBANK]; // inverter ranks
  logic [WORD_W-1:0] wb_reg;          // write-back word
  logic              busy_reg;        // reference in progress
  logic              bank_reg;        // bank of this reference
  logic              wref_reg;        // reference is a write
  logic              wd_q_reg;        // write drive, last cycle
  logic              dd_q_reg;        // dummy drive, last cycle
  logic [9:0]        dmy_cnt_reg;     // dummy-off countdown
  logic [7:0]        rd_cnt_reg;      // cycles into read drive
  logic              en_reg;          // software load enable
  logic [31:0]       refs_reg;        // finished references

  // ----------------------------------------------------------------
  // load selection
  // ----------------------------------------------------------------
  wire ld_req  = i_load_instr | i_load_prog | i_load_preset;
  // a second load is refused until write-back ends
  wire ld_go   = ld_req & en_reg & ~busy_reg;
  // one source wins; instruction first, then program, then preset
  wire [14:0] ld_addr = i_load_instr ? i_instr_addr :
                        i_load_prog  ? i_prog_addr  :
                        {12'h000, i_preset_sel};
  wire ld_bank = ld_addr[0];
  wire wd_fall = wd_q_reg & ~i_write_drive;
  wire dd_rise = i_dummy_drive & ~dd_q_reg;

  // ----------------------------------------------------------------
  // bank address registers: forced copy, no clear pulse
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      s_reg[0] <= '0;
      s_reg[1] <= '0;
    end else if (ld_go) begin
      s_reg[ld_bank] <= ld_addr[14:1];
    end
  end

  // ----------------------------------------------------------------
  // reference tracking
  // ----------------------------------------------------------------
  // a reference ends only at the close of write drive, so the
  // destructive read is always followed by its restore
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      busy_reg <= 1'b0;
      bank_reg <= 1'b0;
      wref_reg <= 1'b0;
      refs_reg <= '0;
    end else if (ld_go) begin
      busy_reg <= 1'b1;
      bank_reg <= ld_bank;
      wref_reg <= i_ref_write;
    end else if (busy_reg && wd_fall) begin
      busy_reg <= 1'b0;
      refs_reg <= refs_reg + 32'h0000_0001;
    end
  end

  // edge history of the sequence strobes
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      wd_q_reg <= 1'b0;
      dd_q_reg <= 1'b0;
    end else begin
      wd_q_reg <= i_write_drive;
      dd_q_reg <= i_dummy_drive;
    end
  end

  // ----------------------------------------------------------------
  // dummy load: on when idle, off a fixed time per reference
  // ----------------------------------------------------------------
  // the window runs from the dummy drive, not from the drivers;
  // the supply tolerates the mismatch
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      dmy_cnt_reg <= '0;
    end else if (busy_reg && dd_rise) begin
      dmy_cnt_reg <= 10'(DUMMY_CYC);
    end else if (dmy_cnt_reg != 10'h000) begin
      dmy_cnt_reg <= dmy_cnt_reg - 10'h001;
    end
  end

  // ----------------------------------------------------------------
  // late-sample gate: cycles since read drive rose
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_sys_rst || !i_read_drive) begin
      rd_cnt_reg <= '0;
    end else if (rd_cnt_reg != 8'hFF) begin
      rd_cnt_reg <= rd_cnt_reg + 8'h01; // saturates
    end
  end
  // early capture would catch half-select noise, so it is ignored
  wire late_ok = rd_cnt_reg >= 8'(SAMPLE_CYC);
  wire cap_go  = i_capture & i_read_drive & late_ok & busy_reg;
  wire rd_ref  = cap_go & ~wref_reg;

  // ----------------------------------------------------------------
  // per-bank translators and inverter ranks
  // ----------------------------------------------------------------
  logic [NDRV-1:0] vrd_n [NBANK];
  logic [NDRV-1:0] vwr_n [NBANK];
  logic [NDRV-1:0] hrd_n [NBANK];
  logic [NDRV-1:0] hwr_n [NBANK];
  logic [NDIV-1:0] vdv_n [NBANK];
  logic [NDIV-1:0] hdv_n [NBANK];

  genvar b, k;
  generate
    for (b = 0; b < NBANK; b++) begin : g_bank
      // low-stage terms, before the drive strobe is applied
      wire [1:0] vlo = {s_reg[b][V_DRV_LO], ~s_reg[b][V_DRV_LO]};
      wire [1:0] hlo = {s_reg[b][H_DRV_LO], ~s_reg[b][H_DRV_LO]};
      wire [1:0] vpr = {s_reg[b][V_DRV_HI], s_reg[b][V_DRV_MD]};
      wire [1:0] hpr = {s_reg[b][H_DRV_HI], s_reg[b][H_DRV_MD]};
      wire [3:0] vdv = s_reg[b][V_DIV_LS+3:V_DIV_LS];
      wire [3:0] hdv = s_reg[b][H_DIV_LS+3:H_DIV_LS];
      wire       act = busy_reg & (bank_reg == b);
      for (k = 0; k < NDRV; k++) begin : g_drv
        // pair term 00X..11X against upper two bits of k
        wire vp = (vpr == k[2:1]);
        wire hp = (hpr == k[2:1]);
        assign vrd_n[b][k] = act & i_read_drive  & vlo[k%2] & vp;
        assign vwr_n[b][k] = act & i_write_drive & vlo[k%2] & vp;
        assign hrd_n[b][k] = act & i_read_drive  & hlo[k%2] & hp;
        assign hwr_n[b][k] = act & i_write_drive & hlo[k%2] & hp;
      end
      for (k = 0; k < NDIV; k++) begin : g_div
        // low pair XX00..XX11 with high pair 00XX..11XX
        wire vl = (vdv[1:0] == k[1:0]);
        wire vh = (vdv[3:2] == k[3:2]);
        wire hl = (hdv[1:0] == k[1:0]);
        wire hh = (hdv[3:2] == k[3:2]);
        assign vdv_n[b][k] = act & vl & vh;
        assign hdv_n[b][k] = act & hl & hh;
      end

      // inverter rank: sense on read, operand on write
      wire rd_in = act & i_read_strobe & (|i_quad_sel) & ~wref_reg;
      wire wr_in = act & i_write_strobe & wref_reg;
      always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
          inv_reg[b] <= '0;
        end else if (rd_in) begin
          inv_reg[b] <= i_sense;
        end else if (wr_in) begin
          inv_reg[b] <= i_operand;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // write-back word, inhibit and outward word
  // ----------------------------------------------------------------
  // first half reads into the rank and write-back word, second
  // half writes that word back under inhibit
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      wb_reg     <= '0;
      o_word     <= '0;
      o_op_load  <= 1'b0;
      o_ctl_load <= 1'b0;
    end else begin
      if (cap_go) begin
        wb_reg <= inv_reg[bank_reg];
      end
      if (rd_ref) begin
        o_word <= inv_reg[bank_reg];
      end
      o_op_load  <= rd_ref & i_cap_to_op;
      o_ctl_load <= rd_ref & i_cap_to_ctl;
    end
  end

  // ----------------------------------------------------------------
  // registered select outputs
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_vdrv_rd  <= '0;
      o_vdrv_wr  <= '0;
      o_hdrv_rd  <= '0;
      o_hdrv_wr  <= '0;
      o_vdiv     <= '0;
      o_hdiv     <= '0;
      o_inhibit  <= '0;
      o_dummy_en <= 1'b1;
      o_busy     <= 1'b0;
    end else begin
      o_vdrv_rd  <= {vrd_n[1], vrd_n[0]};
      o_vdrv_wr  <= {vwr_n[1], vwr_n[0]};
      o_hdrv_rd  <= {hrd_n[1], hrd_n[0]};
      o_hdrv_wr  <= {hwr_n[1], hwr_n[0]};
      o_vdiv     <= {vdv_n[1], vdv_n[0]};
      o_hdiv     <= {hdv_n[1], hdv_n[0]};
      // every zero bit inhibited while write drive is on
      o_inhibit  <= (busy_reg & i_write_drive) ? ~wb_reg : '0;
      o_dummy_en <= (dmy_cnt_reg == 10'h000);
      o_busy     <= busy_reg;
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite slave: write channel
  // ----------------------------------------------------------------
  logic       aw_hold_reg;  // address taken, waiting for data
  logic [7:0] aw_addr_reg;
  logic       w_hold_reg;   // data taken, waiting for address
  logic [31:0] w_data_reg;
  logic [3:0]  w_strb_reg;

  wire aw_take = i_axi.awvalid & o_axi.awready;
  wire w_take  = i_axi.wvalid & o_axi.wready;
  wire aw_have = aw_hold_reg | aw_take;
  wire w_have  = w_hold_reg | w_take;
  wire [7:0]  wa   = aw_hold_reg ? aw_addr_reg : i_axi.awaddr;
  wire [31:0] wd   = w_hold_reg ? w_data_reg : i_axi.wdata;
  wire [3:0]  ws   = w_hold_reg ? w_strb_reg : i_axi.wstrb;
  wire wr_do = aw_have & w_have & ~o_axi.bvalid;
  wire wa_ok = (wa == OFS_CTRL) | (wa == OFS_STAT) | (wa == OFS_BANK0)
             | (wa == OFS_BANK1) | (wa == OFS_WB_LO) | (wa == OFS_WB_HI)
             | (wa == OFS_REFS);

  // ----------------------------------------------------------------
  // AXI4-Lite slave: read data selection
  // ----------------------------------------------------------------
  logic [31:0] rd_mux;
  logic        ra_ok;
  always_comb begin
    ra_ok  = 1'b1;
    case (i_axi.araddr)
      OFS_CTRL:  rd_mux = {31'h0000_0000, en_reg};
      OFS_STAT:  rd_mux = {29'h0000_0000, wref_reg, bank_reg, busy_reg};
      OFS_BANK0: rd_mux = {17'h0_0000, s_reg[0], 1'b0};
      OFS_BANK1: rd_mux = {17'h0_0000, s_reg[1], 1'b1};
      OFS_WB_LO: rd_mux = wb_reg[31:0];
      OFS_WB_HI: rd_mux = {16'h0000, wb_reg[47:32]};
      OFS_REFS:  rd_mux = refs_reg;
      default: begin
        rd_mux = '0;
        ra_ok  = 1'b0;
      end
    endcase
  end

  // one process for both channels: one driver for the response
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_axi.arready <= 1'b1;
      o_axi.rvalid  <= 1'b0;
      o_axi.rdata   <= '0;
      o_axi.rresp   <= RESP_OK;
      aw_hold_reg   <= 1'b0;
      w_hold_reg    <= 1'b0;
      aw_addr_reg   <= '0;
      w_data_reg    <= '0;
      w_strb_reg    <= '0;
      o_axi.awready <= 1'b1;
      o_axi.wready  <= 1'b1;
      o_axi.bvalid  <= 1'b0;
      o_axi.bresp   <= RESP_OK;
      en_reg        <= CTRL_RST;
    end else begin
      if (wr_do) begin
        // both halves present: commit and answer
        aw_hold_reg   <= 1'b0;
        w_hold_reg    <= 1'b0;
        o_axi.awready <= 1'b0;
        o_axi.wready  <= 1'b0;
        o_axi.bvalid  <= 1'b1;
        o_axi.bresp   <= wa_ok ? RESP_OK : RESP_ERR;
        if (wa == OFS_CTRL && ws[0]) begin
          en_reg <= wd[0];
        end
      end else begin
        if (aw_take) begin
          aw_hold_reg   <= 1'b1;
          aw_addr_reg   <= i_axi.awaddr;
          o_axi.awready <= 1'b0;
        end
        if (w_take) begin
          w_hold_reg   <= 1'b1;
          w_data_reg   <= i_axi.wdata;
          w_strb_reg   <= i_axi.wstrb;
          o_axi.wready <= 1'b0;
        end
        if (o_axi.bvalid && i_axi.bready) begin
          o_axi.bvalid  <= 1'b0;
          o_axi.awready <= 1'b1;
          o_axi.wready  <= 1'b1;
        end
      end
      // read channel: answer on the same edge that takes the address
      if (i_axi.arvalid && o_axi.arready) begin
        o_axi.arready <= 1'b0;
        o_axi.rvalid  <= 1'b1;
        o_axi.rdata   <= rd_mux;
        o_axi.rresp   <= ra_ok ? RESP_OK : RESP_ERR;
      end else if (o_axi.rvalid && i_axi.rready) begin
        o_axi.rvalid  <= 1'b0;
        o_axi.arready <= 1'b1;
      end
    end
  end

endmodule

/* File: src/csab_pkg.sv */
// shared constants and carrier types of the core store address and bit-plane block
package csab_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int ADDR_W   = 15;  // full storage address
  localparam int STAGE_W  = 14;  // stages per bank address register
  localparam int WORD_W   = 48;  // bits per stored word
  localparam int NBANK    = 2;   // even bank 0, odd bank 1
  localparam int NDRV     = 8;   // drivers per axis
  localparam int NDIV     = 16;  // diverters per axis

  // ----------------------------------------------------------------
  // stage positions used by the translators (stage n = bit n)
  // ----------------------------------------------------------------
  localparam int V_DRV_HI = 1;   // vertical driver, high stage
  localparam int V_DRV_MD = 8;
  localparam int V_DRV_LO = 7;
  localparam int H_DRV_HI = 2;   // horizontal driver, high stage
  localparam int H_DRV_MD = 14;
  localparam int H_DRV_LO = 13;
  localparam int V_DIV_LS = 3;   // vertical diverter, stages 03..06
  localparam int H_DIV_LS = 9;   // horizontal diverter, stages 09..12

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_NS     = 10;    // clock period
  localparam int DUMMY_NS   = 6200;  // dummy load off time
  localparam int SAMPLE_NS  = 1600;  // least delay into read drive
  localparam int DUMMY_CYC  = DUMMY_NS / CLK_NS;
  localparam int SAMPLE_CYC = (SAMPLE_NS + CLK_NS - 1) / CLK_NS;

  // ----------------------------------------------------------------
  // register map, byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL  = 8'h00;
  localparam logic [7:0] OFS_STAT  = 8'h04;
  localparam logic [7:0] OFS_BANK0 = 8'h08;
  localparam logic [7:0] OFS_BANK1 = 8'h0C;
  localparam logic [7:0] OFS_WB_LO = 8'h10;
  localparam logic [7:0] OFS_WB_HI = 8'h14;
  localparam logic [7:0] OFS_REFS  = 8'h18;
  localparam logic [1:0] RESP_OK   = 2'h0;
  localparam logic [1:0] RESP_ERR  = 2'h2;
  localparam logic       CTRL_RST  = 1'b1;  // loads accepted after reset

  // ----------------------------------------------------------------
  // bus carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        awvalid;
    logic [7:0]  awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [7:0]  araddr;
    logic        rready;
  } csab_axi_req_s;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } csab_axi_rsp_s;

endpackage
